// File: logic/gpb_port_bank.sv
// Purpose: Eight-pin general purpose port slice with Avalon-MM registers.
// Assumes: Pin, peripheral and low-power inputs arrive as plain levels.
// Notes:   Avalon lock marks the read of a read-modify-write.
//
// Function
// [R1] Bit y of every register governs pin y.
// [R2] Input pin: read pin level, write latch only.
// [R3] Output pin: read latch, write drives pin.
// [R4] Plain read: direction 0 pin, 1 latch.
// [R5] Read-modify-write read always returns the latch.
// [R6] Pin level mirror is read-only.
// [R7] Mirror bit tracks pin only when gated.
// [R8] Direction 0 input, 1 output, reset 0.
// [R9] Direction readable, ignored on analog pins.
// [R10] Input gate 0 blocks, 1 passes, reset 0.
// [R11] Analog function forces digital input off.
// [R12] Low-power mode disables inputs except interrupt pins.
// [R13] Strong drive bit enables high drive, reset 0.
// [R14] Pull-up bit connects pull-up on input pins.
// [R15] No pull-up on outputs or floated low-power.
// [R16] Pull-down bit connects pull-down on input pins.
// [R17] No pull-down on outputs or floated low-power.
// [R18] Peripheral output overrides direction, kills pulls.
// [R19] Two-wire bus pins keep their pull-up.
// [R20] Peripheral input sees pin only when gated.
// [R21] Pin levels pass two synchroniser flops.
//
// The Avalon-MM register port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`include "gpb_defs.svh"
module gpb_port_bank
   import gpb_pkg::*;
(
   input  wire logic                  core_clk,
   input  wire logic                  reset,
   input  wire logic [`GPB_ADDR_W-1:0] avs_address,
   input  wire logic                  avs_read,
   input  wire logic                  avs_write,
   input  wire logic                  avs_lock,
   input  wire logic [3:0]            avs_byteenable,
   input  wire logic [31:0]           avs_writedata,
   output logic      [31:0]           avs_readdata,
   output logic                       avs_waitrequest,
   input  wire logic [7:0]            port_pin_in,
   output logic      [7:0]            port_pin_out,
   output logic      [7:0]            port_pin_oe_n,
   output logic      [7:0]            strong_drive_en,
   output logic      [7:0]            pull_up_en,
   output logic      [7:0]            pull_down_en,
   output logic      [7:0]            input_buffer_en,
   input  wire logic [7:0]            periph_oe,
   input  wire logic [7:0]            periph_out,
   output logic      [7:0]            periph_in,
   input  wire logic [7:0]            analog_input_select,
   input  wire logic [7:0]            twi_pin_select,
   input  wire logic [7:0]            ext_irq_active,
   input  wire logic                  low_power_mode_control,
   input  wire logic                  low_power_pin_float
);

   // ----------------------------------------------------------------------
   // Storage and internal nets
   // ----------------------------------------------------------------------
   gpb_byte_t      port_output_latch;
   gpb_byte_t      pin_direction;
   gpb_byte_t      digital_input_gate;
   gpb_byte_t      strong_drive_select;
   gpb_byte_t      pull_up_select;
   gpb_byte_t      pull_down_select;
   gpb_byte_t      pin_level_mirror;
   gpb_byte_t      input_path_open;
   gpb_byte_t      data_read_value;
   gpb_byte_t      next_pin_out;
   gpb_byte_t      next_pin_oe_n;
   gpb_byte_t      next_pull_up;
   gpb_byte_t      next_pull_down;
   gpb_bus_state_t bus_state;
   gpb_byte_t      next_read_byte;
   logic           write_fire;
   logic           low_byte_write;
   logic           pins_floated;

   gpb_sync_if sio ();

   // Pin levels reach the core only through the synchroniser.
   assign sio.pin_raw = port_pin_in;

   // [R21] synchronise pin levels
   gpb_pin_sync u_pin_sync (
      .core_clk (core_clk),
      .reset    (reset),
      .sio      (sio)
   );

   // ----------------------------------------------------------------------
   // Avalon-MM handshake
   // ----------------------------------------------------------------------
   // Every access waits exactly one cycle; the answer is registered so the
   // read mux never sits on the bus path combinationally.
   always_ff @(posedge core_clk) begin
      if (reset) begin
         bus_state <= GPB_IDLE;
      end else begin
         unique case (bus_state)
            GPB_IDLE: begin
               if (avs_read || avs_write) begin
                  bus_state <= GPB_ANSWER;
               end
            end
            GPB_ANSWER: begin
               bus_state <= GPB_IDLE;
            end
         endcase
      end
   end

   // Waitrequest is high except in the answer cycle.
   always_ff @(posedge core_clk) begin
      if (reset) begin
         avs_waitrequest <= 1'b1;
      end else begin
         avs_waitrequest <= !((bus_state == GPB_IDLE) && (avs_read || avs_write));
      end
   end

   // A write commits at the edge where waitrequest is seen low.
   assign write_fire     = avs_write && (bus_state == GPB_ANSWER);
   assign low_byte_write = write_fire && avs_byteenable[0];

   // ----------------------------------------------------------------------
   // Writable registers
   // ----------------------------------------------------------------------
   // [R2] [R3] [R18] writes only ever load the latch
   // Whether the latch reaches the pin is decided by the pad logic below.
   always_ff @(posedge core_clk) begin
      if (reset) begin
         port_output_latch <= `GPB_RST_LATCH;
      end else if (low_byte_write && (avs_address == `GPB_OFF_LATCH)) begin
         port_output_latch <= avs_writedata[`GPB_PORT_MSB:`GPB_PORT_LSB];
      end
   end

   // [R8] [R10] [R13] [R14] [R16] control registers reset to zero
   // The mirror has no write path at all, so writes to it fall away.
   always_ff @(posedge core_clk) begin
      if (reset) begin
         pin_direction       <= `GPB_RST_CONTROL;
         digital_input_gate  <= `GPB_RST_CONTROL;
         strong_drive_select <= `GPB_RST_CONTROL;
         pull_up_select      <= `GPB_RST_CONTROL;
         pull_down_select    <= `GPB_RST_CONTROL;
      end else if (low_byte_write) begin
         unique case (avs_address)
            `GPB_OFF_DIRECTION:  pin_direction <= avs_writedata[7:0];
            `GPB_OFF_INPUT_GATE: digital_input_gate <= avs_writedata[7:0];
            `GPB_OFF_STRONG:     strong_drive_select <= avs_writedata[7:0];
            `GPB_OFF_PULL_UP:    pull_up_select <= avs_writedata[7:0];
            `GPB_OFF_PULL_DOWN:  pull_down_select <= avs_writedata[7:0];
            default: begin
            end
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // Per-pin logic
   // ----------------------------------------------------------------------
   // Floating in low power releases every pull at once.
   assign pins_floated = low_power_mode_control && low_power_pin_float;

   // [R1] one slice of logic per pin index
   for (genvar y = 0; y < 8; y++) begin : g_pin
      // [R10] [R11] [R12] open input path
      // Interrupt pins stay awake in low power so they can wake the core.
      assign input_path_open[y] = digital_input_gate[y] && !analog_input_select[y]
                                  && (!low_power_mode_control || ext_irq_active[y]);

      // [R7] mirror follows pin only when the path is open
      assign pin_level_mirror[y] = sio.pin_sync[y] && input_path_open[y];

      // [R4] [R5] latch for output or read-modify-write, else pin
      assign data_read_value[y] = (avs_lock || pin_direction[y])
                                  ? port_output_latch[y] : pin_level_mirror[y];

      // [R3] [R9] [R18] pad driver selection
      // Analog pins ignore direction and peripheral enable; elsewhere a peripheral owns the pad outright.
      always_comb begin
         next_pin_out[y]  = periph_oe[y] ? periph_out[y] : port_output_latch[y];
         next_pin_oe_n[y] = !(!analog_input_select[y]
                              && (periph_oe[y] || pin_direction[y]));
      end

      // [R14] [R15] [R18] [R19] pull-up enable
      always_comb begin
         next_pull_up[y] = pull_up_select[y] && !analog_input_select[y]
                           && !pins_floated && !pin_direction[y]
                           && (!periph_oe[y] || twi_pin_select[y]);
      end

      // [R16] [R17] [R18] pull-down enable
      always_comb begin
         next_pull_down[y] = pull_down_select[y] && !analog_input_select[y]
                             && !pins_floated && !pin_direction[y] && !periph_oe[y];
      end
   end

   // ----------------------------------------------------------------------
   // Pad and peripheral outputs
   // ----------------------------------------------------------------------
   // Registered so every pad control changes cleanly once per clock.
   always_ff @(posedge core_clk) begin
      if (reset) begin
         port_pin_out    <= `GPB_RST_LATCH;
         port_pin_oe_n   <= ~`GPB_RST_CONTROL;
         pull_up_en      <= `GPB_RST_CONTROL;
         pull_down_en    <= `GPB_RST_CONTROL;
         strong_drive_en <= `GPB_RST_CONTROL;
      end else begin
         port_pin_out    <= next_pin_out;
         port_pin_oe_n   <= next_pin_oe_n;
         pull_up_en      <= next_pull_up;
         pull_down_en    <= next_pull_down;
         // [R13] strong drive straight from its select
         strong_drive_en <= strong_drive_select;
      end
   end

   // [R20] peripherals see the pin only through the open path
   always_ff @(posedge core_clk) begin
      if (reset) begin
         input_buffer_en <= `GPB_RST_CONTROL;
         periph_in       <= `GPB_RST_CONTROL;
      end else begin
         input_buffer_en <= input_path_open;
         periph_in       <= sio.pin_sync & input_path_open;
      end
   end

   // ----------------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------------
   // Unmapped offsets answer with zero; upper bits always read zero.
   always_comb begin
      next_read_byte = `GPB_RST_CONTROL;
      unique case (avs_address)
         `GPB_OFF_LATCH:      next_read_byte = data_read_value;
         // [R6] mirror read-only view
         `GPB_OFF_MIRROR:     next_read_byte = pin_level_mirror;
         // [R9] direction readable whatever the pin owner
         `GPB_OFF_DIRECTION:  next_read_byte = pin_direction;
         `GPB_OFF_INPUT_GATE: next_read_byte = digital_input_gate;
         `GPB_OFF_STRONG:     next_read_byte = strong_drive_select;
         `GPB_OFF_PULL_UP:    next_read_byte = pull_up_select;
         `GPB_OFF_PULL_DOWN:  next_read_byte = pull_down_select;
         default:             next_read_byte = `GPB_RST_CONTROL;
      endcase
   end

   // Read data are captured on the cycle the request is first seen.
   always_ff @(posedge core_clk) begin
      if (reset) begin
         avs_readdata <= `GPB_RST_READDATA;
      end else if ((bus_state == GPB_IDLE) && avs_read) begin
         avs_readdata <= {24'h00_0000, next_read_byte};
      end
   end

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   default clocking gpb_cb @(posedge core_clk);
   endclocking
   default disable iff (reset);

   logic [2:0] reset_age;

   // Counts clean cycles after reset so pipeline checks start valid.
   always_ff @(posedge core_clk) begin
      if (reset) begin
         reset_age <= 3'h0;
      end else if (reset_age != 3'h7) begin
         reset_age <= reset_age + 3'h1;
      end
   end

   chk_wait_answer: assert property ( // bus
      (bus_state == GPB_IDLE) && (avs_read || avs_write) |=> !avs_waitrequest ##1 avs_waitrequest)
      else $error("waitrequest did not drop for exactly one cycle");

   // [R5] read-modify-write returns latch
   chk_rmw_latch: assert property ( // [R5]
      (bus_state == GPB_IDLE) && avs_read && avs_lock && (avs_address == `GPB_OFF_LATCH)
      |=> avs_readdata == {24'h00_0000, $past(port_output_latch)})
      else $error("read-modify-write read did not return the latch");

   // [R4] plain read picks pin or latch
   chk_plain_read: assert property ( // [R4]
      (bus_state == GPB_IDLE) && avs_read && !avs_lock && (avs_address == `GPB_OFF_LATCH)
      |=> avs_readdata[7:0] == (($past(pin_direction) & $past(port_output_latch))
                               | (~$past(pin_direction) & $past(pin_level_mirror))))
      else $error("plain data read returned the wrong source");

   // [R2] write lands in the latch
   chk_latch_write: assert property ( // [R2]
      write_fire && avs_byteenable[0] && (avs_address == `GPB_OFF_LATCH)
      |=> port_output_latch == $past(avs_writedata[7:0]))
      else $error("latch did not take the written value");

   // [R3] output pin drives latch
   chk_output_drive: assert property ( // [R3]
      (pin_direction == 8'hFF) && (periph_oe == 8'h00) && (analog_input_select == 8'h00)
      |=> (port_pin_oe_n == 8'h00) && (port_pin_out == $past(port_output_latch)))
      else $error("output pins not driving the latch");

   // [R8] direction resets to input
   chk_dir_reset: assert property ( // [R8]
      (reset_age == 3'h1) |-> (pin_direction == 8'h00) && (port_pin_oe_n == 8'hFF))
      else $error("direction not input after reset");

   // [R11] analog pins have no input
   chk_analog_gate: assert property ( // [R11]
      1'b1 |=> (input_buffer_en & $past(analog_input_select)) == 8'h00)
      else $error("digital input open on an analog pin");

   // [R12] low power closes inputs
   chk_stop_gate: assert property ( // [R12]
      low_power_mode_control && (ext_irq_active == 8'h00) |=> input_buffer_en == 8'h00)
      else $error("input open in low-power mode");

   // [R15] [R17] floating releases pulls
   chk_float_pulls: assert property ( // [R15]
      pins_floated |=> (pull_up_en == 8'h00) && (pull_down_en == 8'h00))
      else $error("pull left on while pins float");

   // [R18] peripheral output kills pull-down
   chk_periph_pull: assert property ( // [R18]
      1'b1 |=> (pull_down_en & $past(periph_oe)) == 8'h00)
      else $error("pull-down on a peripheral-driven pin");

   // [R21] [R20] three-cycle gated pin path
   chk_sync_delay: assert property ( // [R21]
      (reset_age == 3'h7) |-> periph_in == ($past(port_pin_in, 3) & $past(input_path_open)))
      else $error("peripheral input not the gated, twice-synchronised pin");

   cov_rmw_read: cover property (
      (bus_state == GPB_IDLE) && avs_read && avs_lock && (avs_address == `GPB_OFF_LATCH));
   cov_latch_write: cover property (
      write_fire && (avs_address == `GPB_OFF_LATCH));
   cov_periph_own: cover property (
      (periph_oe != 8'h00) && (pin_direction == 8'h00));
   cov_low_power: cover property (
      low_power_mode_control && (ext_irq_active != 8'h00));

endmodule : gpb_port_bank

// File: logic/gpb_defs.svh
// Purpose: Offsets, reset values and sizes of the port bank.
// Assumes: Avalon-MM byte addresses, one 32-bit word per register.
// Notes:   Definitions only.
`ifndef GPB_DEFS_SVH
`define GPB_DEFS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define GPB_ADDR_W          5
`define GPB_OFF_LATCH       5'h00
`define GPB_OFF_MIRROR      5'h04
`define GPB_OFF_DIRECTION   5'h08
`define GPB_OFF_INPUT_GATE  5'h0C
`define GPB_OFF_STRONG      5'h10
`define GPB_OFF_PULL_UP     5'h14
`define GPB_OFF_PULL_DOWN   5'h18

// ----------------------------------------------------------------------
// Reset values and field positions
// ----------------------------------------------------------------------
`define GPB_RST_LATCH       8'h00
`define GPB_RST_CONTROL     8'h00
`define GPB_RST_READDATA    32'h0000_0000
`define GPB_PORT_LSB        0
`define GPB_PORT_MSB        7

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define GPB_SYNC_STAGES     2
`define GPB_READ_LATENCY    1

`endif

// File: logic/gpb_pkg.sv
// Purpose: Shared types of the port bank.
// Assumes: Eight pins per slice.
// Notes:   Constants live in gpb_defs.svh.
package gpb_pkg;

   // ----------------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------------
   typedef logic [7:0] gpb_byte_t;

   // Bus slave handshake states.
   typedef enum logic {
      GPB_IDLE,
      GPB_ANSWER
   } gpb_bus_state_t;

endpackage : gpb_pkg

// File: logic/gpb_sync_if.sv
// Purpose: Carries raw and synchronised pin levels between modules.
// Assumes: One clock domain.
// Notes:   The synchroniser drives the sync side, the top the raw side.
`timescale 1ns/10ps
interface gpb_sync_if
   import gpb_pkg::*;
();
   gpb_byte_t pin_raw;
   gpb_byte_t pin_sync;

   // The top supplies raw levels and reads the resolved ones.
   modport user (output pin_raw, input pin_sync);
   // The synchroniser consumes raw levels.
   modport sync (input pin_raw, output pin_sync);
endinterface : gpb_sync_if

// File: logic/gpb_pin_sync.sv
// Purpose: Two-stage synchroniser for the external pin levels.
// Assumes: Pins are asynchronous to core_clk.
// Notes:   First stage is read by the second stage only.
`timescale 1ns/10ps
`include "gpb_defs.svh"
module gpb_pin_sync
   import gpb_pkg::*;
(
   input  wire logic core_clk,
   input  wire logic reset,
   gpb_sync_if.sync  sio
);
   gpb_byte_t stage_one;
   gpb_byte_t stage_two;

   // ----------------------------------------------------------------------
   // Synchroniser stages
   // ----------------------------------------------------------------------
   // [R21] two-flop pin synchroniser
   // Metastability settles in stage_one before anyone looks at it.
   always_ff @(posedge core_clk) begin
      if (reset) begin
         stage_one <= `GPB_RST_LATCH;
         stage_two <= `GPB_RST_LATCH;
      end else begin
         stage_one <= sio.pin_raw;
         stage_two <= stage_one;
      end
   end

   assign sio.pin_sync = stage_two;
endmodule : gpb_pin_sync

// File: tb/gpb_pad_model.sv
// Purpose: Pad and board model that resolves the level seen on each port pin.
// Assumes: Design drive wins, then the bench's external driver, then pulls.
// Notes:   An undriven, unpulled pin toggles every cycle so no stale level can pass.
`timescale 1ns/10ps
module gpb_pad_model
   import gpb_pkg::*;
(
   input  wire logic       core_clk,
   input  wire logic [7:0] pin_out,
   input  wire logic [7:0] pin_oe_n,
   input  wire logic [7:0] pull_up,
   input  wire logic [7:0] pull_down,
   input  wire logic [7:0] ext_en,
   input  wire logic [7:0] ext_val,
   output logic      [7:0] pin_level
);
   gpb_byte_t float_pat = 8'h55;

   // A floating pad shows a changing pattern rather than a held value.
   always_ff @(posedge core_clk) begin
      float_pat <= ~float_pat;
   end

   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (pin_oe_n[i] == 1'b0) pin_level[i] = pin_out[i];
         else if (ext_en[i]) pin_level[i] = ext_val[i];
         else if (pull_up[i]) pin_level[i] = 1'b1;
         else if (pull_down[i]) pin_level[i] = 1'b0;
         else pin_level[i] = float_pat[i];
      end
   end
endmodule : gpb_pad_model

// File: tb/general_purpose_port_bank_tb.sv
// Purpose: Self-checking bench of the port bank through Avalon-MM and the pads.
// Assumes: Registered outputs settle one edge after a change, pins three edges.
// Notes:   Reads that show pin levels wait five cycles after every change.
`timescale 1ns/10ps
`include "gpb_defs.svh"
module general_purpose_port_bank_tb
   import gpb_pkg::*;
;
   typedef struct packed {
      gpb_byte_t dir, gate, latch, ext;
      logic      lock;
      gpb_byte_t exp_data, exp_mirror;
   } gpb_row_t;
   logic core_clk = 1'b0, reset = 1'b1, avs_read = 1'b0, avs_write = 1'b0, avs_lock = 1'b0;
   logic [4:0]  avs_address = 5'h00;
   logic [3:0]  avs_byteenable = 4'hF;
   logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, rd;
   logic        avs_waitrequest, low_power_mode_control = 1'b0, low_power_pin_float = 1'b0;
   gpb_byte_t   port_pin_in, port_pin_out, port_pin_oe_n, strong_drive_en, pull_up_en;
   gpb_byte_t   pull_down_en, input_buffer_en, periph_in, ext_en = 8'h00, ext_val = 8'h00;
   gpb_byte_t   periph_oe = 8'h00, periph_out = 8'h00, analog_input_select = 8'h00;
   gpb_byte_t   twi_pin_select = 8'h00, ext_irq_active = 8'h00;
   int          errors = 0, compares = 0;
   gpb_row_t    rows [5] = '{
      '{8'h00, 8'hFF, 8'h5A, 8'hC3, 1'b0, 8'hC3, 8'hC3},
      '{8'h00, 8'hFF, 8'h5A, 8'hC3, 1'b1, 8'h5A, 8'hC3},
      '{8'hFF, 8'hFF, 8'hA5, 8'h00, 1'b0, 8'hA5, 8'hA5},
      '{8'hF0, 8'h0F, 8'h3C, 8'h96, 1'b0, 8'h36, 8'h06},
      '{8'h0F, 8'hFF, 8'h81, 8'h7E, 1'b1, 8'h81, 8'h71}};

   // The pads sit between the design and the bench's external drivers.
   gpb_pad_model u_gpb_pad_model (.core_clk(core_clk), .pin_out(port_pin_out),
      .pin_oe_n(port_pin_oe_n), .pull_up(pull_up_en), .pull_down(pull_down_en),
      .ext_en(ext_en), .ext_val(ext_val), .pin_level(port_pin_in));
   gpb_port_bank u_gpb_port_bank (.core_clk(core_clk), .reset(reset),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_lock(avs_lock), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .port_pin_in(port_pin_in), .port_pin_out(port_pin_out), .port_pin_oe_n(port_pin_oe_n),
      .strong_drive_en(strong_drive_en), .pull_up_en(pull_up_en),
      .pull_down_en(pull_down_en), .input_buffer_en(input_buffer_en),
      .periph_oe(periph_oe), .periph_out(periph_out), .periph_in(periph_in),
      .analog_input_select(analog_input_select), .twi_pin_select(twi_pin_select),
      .ext_irq_active(ext_irq_active), .low_power_mode_control(low_power_mode_control),
      .low_power_pin_float(low_power_pin_float));

   // ----------------------------------------------------------------------
   // Clock, watchdog and reporting
   // ----------------------------------------------------------------------
   initial begin
      forever #25 core_clk = ~core_clk;
   end
   // The tests need about 260 cycles; the watchdog allows 15000 cycles.
   initial begin
      #(50 * 15000);
      errors++;
      finish_test();
   end
   task automatic finish_test();
      $display("errors=%0d compares=%0d", errors, compares);
      if (errors == 0 && compares > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : finish_test
   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_reg
   task automatic chk_pad(input gpb_byte_t got, input gpb_byte_t exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_pad

   // ----------------------------------------------------------------------
   // Avalon-MM master
   // ----------------------------------------------------------------------
   // The request is held until waitrequest is seen low at a rising edge.
   // No local limit: only the watchdog may end a wait that never answers.
   task automatic wait_answer();
      do begin
         @(posedge core_clk);
      end while (avs_waitrequest !== 1'b0);
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
      avs_lock  <= 1'b0;
   endtask : wait_answer
   task automatic bus_write(input logic [4:0] a, input gpb_byte_t d, input logic [3:0] be);
      @(posedge core_clk);
      avs_address    <= a;
      avs_writedata  <= {24'h00_0000, d};
      avs_byteenable <= be;
      avs_write      <= 1'b1;
      wait_answer();
   endtask : bus_write
   task automatic bus_read(input logic [4:0] a, input logic lk, output logic [31:0] d);
      @(posedge core_clk);
      avs_address <= a;
      avs_lock    <= lk;
      avs_read    <= 1'b1;
      wait_answer();
      d = avs_readdata;
   endtask : bus_read
   task automatic settle();
      repeat (5) @(posedge core_clk);
   endtask : settle
   // Reset state of every readable place except the mirror, the unmapped word included.
   task automatic check_reset_values();
      logic [4:0] offs [7];
      offs = '{5'h00, 5'h08, 5'h0C, 5'h10, 5'h14, 5'h18, 5'h1C};
      foreach (offs[i]) begin
         bus_read(offs[i], 1'b0, rd);
         chk_reg(rd, `GPB_RST_READDATA);
      end
      chk_pad(port_pin_oe_n, 8'hFF);
      chk_pad(pull_up_en | pull_down_en | strong_drive_en | input_buffer_en, 8'h00);
   endtask : check_reset_values

   // ----------------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------------
   initial begin
      repeat (20) @(posedge core_clk);
      reset <= 1'b0;
      check_reset_values();
      // Table of plain port cases, direction varied per pin and read kind per row.
      foreach (rows[i]) begin
         bus_write(`GPB_OFF_DIRECTION, rows[i].dir, 4'hF);
         bus_write(`GPB_OFF_INPUT_GATE, rows[i].gate, 4'hF);
         bus_write(`GPB_OFF_LATCH, rows[i].latch, 4'hF);
         ext_en  <= ~rows[i].dir;
         ext_val <= rows[i].ext;
         settle();
         bus_read(`GPB_OFF_LATCH, rows[i].lock, rd);
         chk_reg(rd, {24'h00_0000, rows[i].exp_data});
         bus_read(`GPB_OFF_MIRROR, 1'b0, rd);
         chk_reg(rd, {24'h00_0000, rows[i].exp_mirror});
         chk_pad(periph_in, rows[i].exp_mirror);
         chk_pad(port_pin_oe_n, ~rows[i].dir);
         chk_pad(port_pin_out & rows[i].dir, rows[i].latch & rows[i].dir);
      end
      // Mirror writes and disabled byte lanes leave state alone.
      bus_write(`GPB_OFF_MIRROR, 8'h00, 4'hF);
      bus_write(`GPB_OFF_DIRECTION, 8'h00, 4'h0);
      bus_read(`GPB_OFF_MIRROR, 1'b0, rd);
      chk_reg(rd, 32'h0000_0071);
      bus_read(`GPB_OFF_DIRECTION, 1'b0, rd);
      chk_reg(rd, 32'h0000_000F);
      bus_write(`GPB_OFF_STRONG, 8'h3C, 4'hF);
      bus_read(`GPB_OFF_STRONG, 1'b0, rd);
      chk_reg(rd, 32'h0000_003C);
      chk_pad(strong_drive_en, 8'h3C);
      // Pulls act on input pins only and are released by the pin float only in low-power mode.
      bus_write(`GPB_OFF_PULL_UP, 8'h33, 4'hF);
      bus_write(`GPB_OFF_PULL_DOWN, 8'hCC, 4'hF);
      ext_en <= 8'h00;
      settle();
      chk_pad(pull_up_en, 8'h30);
      chk_pad(pull_down_en, 8'hC0);
      low_power_pin_float <= 1'b1;
      settle();
      chk_pad(pull_up_en, 8'h30);
      low_power_mode_control <= 1'b1;
      settle();
      chk_pad(input_buffer_en, 8'h00);
      ext_irq_active <= 8'h05;
      settle();
      chk_pad(pull_up_en | pull_down_en, 8'h00);
      chk_pad(input_buffer_en, 8'h05);
      low_power_mode_control <= 1'b0;
      low_power_pin_float <= 1'b0;
      // Analog pins lose drive and the digital input; direction still reads back.
      analog_input_select <= 8'h80;
      bus_write(`GPB_OFF_DIRECTION, 8'hFF, 4'hF);
      settle();
      chk_pad(input_buffer_en, 8'h7F);
      chk_pad(port_pin_oe_n, 8'h80);
      bus_read(`GPB_OFF_DIRECTION, 1'b0, rd);
      chk_reg(rd, 32'h0000_00FF);
      analog_input_select <= 8'h00;
      // Peripheral ownership of pins 0 and 1; pin 0 is a two-wire line.
      bus_write(`GPB_OFF_DIRECTION, 8'h00, 4'hF);
      bus_write(`GPB_OFF_PULL_UP, 8'hFF, 4'hF);
      bus_write(`GPB_OFF_PULL_DOWN, 8'hFF, 4'hF);
      bus_write(`GPB_OFF_LATCH, 8'hFF, 4'hF);
      periph_oe <= 8'h03;
      periph_out <= 8'h02;
      twi_pin_select <= 8'h01;
      settle();
      chk_pad(port_pin_oe_n, 8'hFC);
      chk_pad(port_pin_out & 8'h03, 8'h02);
      chk_pad(pull_up_en, 8'hFD);
      chk_pad(pull_down_en, 8'hFC);
      chk_pad(periph_in & 8'h03, 8'h02);
      bus_read(`GPB_OFF_LATCH, 1'b1, rd);
      chk_reg(rd, 32'h0000_00FF);
      // A second reset in mid-run returns every register to its reset value.
      @(posedge core_clk);
      reset <= 1'b1;
      periph_oe <= 8'h00;
      repeat (20) @(posedge core_clk);
      reset <= 1'b0;
      check_reset_values();
      finish_test();
   end
endmodule : general_purpose_port_bank_tb
